//--- flash_guard_pkg.sv
// package: register map, field positions and reset values of the flash status/guard block
package flash_guard_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (index times four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FLASH_STATUS = 8'h05;
  localparam logic [7:0] IDX_PROTECTION_CONFIG = 8'h04;
  localparam logic [7:0] IDX_FLASH_CONFIGURATION = 8'h03;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h12;
  localparam logic [7:0] IDX_TIMEBASE_DIVIDER = 8'h00;
  localparam logic [9:0] ADDR_FLASH_STATUS = {IDX_FLASH_STATUS, 2'b00};
  localparam logic [9:0] ADDR_PROTECTION_CONFIG = {IDX_PROTECTION_CONFIG, 2'b00};
  localparam logic [9:0] ADDR_FLASH_CONFIGURATION = {IDX_FLASH_CONFIGURATION, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_MODE_CTRL = {IDX_MODE_CTRL, 2'b00};
  localparam logic [9:0] ADDR_TIMEBASE_DIVIDER = {IDX_TIMEBASE_DIVIDER, 2'b00};

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_BUF_EMPTY = 7;
  localparam int BIT_ALL_DONE = 6;
  localparam int BIT_PROTECT_VIOLATION_FLAG = 5;
  localparam int BIT_ACCESS_ERROR_FLAG = 4;
  localparam int BIT_BLANK = 2;
  localparam int BIT_FAIL = 1;
  localparam int BIT_DONE = 0;

  // configuration bit positions
  localparam int BIT_BE_IE = 7;
  localparam int BIT_AD_IE = 6;

  // interrupt status bit positions
  localparam int IRQ_BUF_EMPTY = 0;
  localparam int IRQ_ALL_DONE = 1;
  localparam int IRQ_PROTECT_VIOLATION_FLAG = 2;
  localparam int IRQ_ACCESS_ERROR_FLAG = 3;
  localparam int IRQ_BITS = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_SCENARIO = 3'h7;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [IRQ_BITS-1:0] RST_IRQ = 4'h0;

endpackage : flash_guard_pkg

//--- flash_protect_status_flags.sv
// flash status flags, protection guard, launch gating and apb register file
`timescale 1ns/1ps
module flash_protect_status_flags
  import flash_guard_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // controller side
  input wire logic array_write_i,
  input wire logic cmd_write_i,
  input wire logic cmd_illegal_i,
  input wire logic target_protected_i,
  input wire logic is_verify_i,
  input wire logic cmd_active_i,
  input wire logic cmd_pending_i,
  input wire logic cmd_finish_i,
  input wire logic verify_erased_i,
  input wire logic stop_req_i,
  input wire logic special_mode_i,
  output logic launch_o,
  output logic abort_o,
  output logic buf_empty_irq_o,
  output logic all_done_irq_o,
  output logic irq_o,
  output logic [2:0] scenario_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARRAY, SEQ_CMD} seq_e;
  seq_e seq_r;
  logic buf_empty_r, all_done_r, protect_violation_flag_r, access_error_flag_r, blank_r, fail_r;
  logic [2:0] scenario_r;
  logic [7:0] config_r;
  logic div_written_r;
  logic [IRQ_BITS-1:0] irq_sts_r, irq_mask_r;
  logic stop_s1_r, stop_s2_r;
  logic wr_acc, rd_acc;
  logic wr_status, launch_req, launch_ok, zero_abort, stop_err;
  logic [IRQ_BITS-1:0] irq_evt;
  logic [7:0] status_rd;

  // ----------------------------------------------------------------
  // behaviour notes for whoever integrates this block
  // ----------------------------------------------------------------
  // register access
  //   every register is one aligned word, eight live bits at most
  //   reads are built in the setup cycle and stand with ready
  //   writes land at the access edge, never at setup
  //   ready comes one cycle after setup: no wait states at all
  //   unmapped addresses answer with a slave error, data zero
  //   upper read bits are always zero
  //
  // protection guard
  //   the stored scenario only moves along the allowed table
  //   a refused write is dropped silently, no error flag is raised
  //   so software must read back the scenario to learn the outcome
  //   reset leaves scenario seven, from which every move is legal
  //   the guard only stores the scenario; range decode lives elsewhere
  //
  // command write sequence
  //   step one: an aligned word write into flash space
  //   step two: a command code write
  //   step three: a one written to buffer-empty launches
  //   a zero to buffer-empty after step one aborts the sequence
  //   the abort raises access error and drops back to idle
  //   a zero written with no sequence open changes nothing
  //   a one written with no sequence open changes nothing either
  //
  // launch gating
  //   no launch while violation, access error or fail is set
  //   an unwritten divider turns a launch into an access error
  //   an illegal code or protected target sets its flag instead
  //   the launch pulse is one cycle, registered, after the write
  //   code and target checks are sampled at the launch write only
  //
  // buffer-empty and all-done
  //   buffer-empty drops on launch and rises once nothing waits
  //   all-done drops whenever buffer-empty is low
  //   all-done rises on a finish with nothing pending
  //   a finish that pulls in a buffered command leaves it low
  //   hazard: a finish in the very cycle buffer-empty rises is lost
  //   so the controller must drain the buffer before finishing
  //
  // error flags
  //   violation and access error are write-one-to-clear
  //   a hardware set in the same cycle as a clear wins
  //   a stop request is synchronised over two flops first
  //   stop only counts as an error while a command is active
  //
  // verify results
  //   blank rises on an erase verify that finds the array erased
  //   blank falls on the next accepted launch only
  //   fail rises on a failing verify in special mode only
  //   fail reads zero and ignores writes in normal modes
  //   done follows the active level, inverted, in special mode
  //
  // interrupts
  //   the two flag interrupts are plain and-gates, registered
  //   the summary line uses its own sticky status and mask
  //   status bits are write-one-to-clear, new events win
  //   the summary interrupt follows the mask one cycle late
  //
  // legal scenario transition lookup
  function automatic logic scenario_ok(input logic [2:0] from, input logic [2:0] to);
    logic [7:0] row;
    row = 8'h00;
    unique case (from)
      3'd0: row = 8'h0F;
      3'd1: row = 8'h0A;
      3'd2: row = 8'h0C;
      3'd3: row = 8'h08;
      3'd4: row = 8'h18;
      3'd5: row = 8'h3C;
      3'd6: row = 8'h5A;
      3'd7: row = 8'hFF;
    endcase
    return row[to];
  endfunction : scenario_ok

  // ----------------------------------------------------------------
  // apb decode: zero wait state access
  // ----------------------------------------------------------------
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign wr_status = wr_acc & (paddr_i == ADDR_FLASH_STATUS);

  // launch, abort and stop conditions
  assign launch_req = wr_status & pwdata_i[BIT_BUF_EMPTY] & (seq_r == SEQ_CMD);
  assign launch_ok = launch_req & ~protect_violation_flag_r & ~access_error_flag_r & ~fail_r & div_written_r
                     & ~cmd_illegal_i & ~target_protected_i;
  assign zero_abort = wr_status & ~pwdata_i[BIT_BUF_EMPTY] & (seq_r != SEQ_IDLE);
  assign stop_err = stop_s2_r & cmd_active_i;
  assign irq_evt[IRQ_BUF_EMPTY] = 1'b0;
  assign irq_evt[IRQ_ALL_DONE] = cmd_finish_i & ~cmd_pending_i;
  assign irq_evt[IRQ_PROTECT_VIOLATION_FLAG] = launch_req & target_protected_i;
  assign irq_evt[IRQ_ACCESS_ERROR_FLAG] = zero_abort | stop_err | (launch_req & cmd_illegal_i);

  // ----------------------------------------------------------------
  // stop request synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
    end else begin
      stop_s1_r <= stop_req_i;
      stop_s2_r <= stop_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // command write sequence tracker
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r <= SEQ_IDLE;
    end else if (zero_abort | launch_req) begin
      seq_r <= SEQ_IDLE;
    end else if (array_write_i) begin
      seq_r <= SEQ_ARRAY;
    end else if (cmd_write_i && seq_r == SEQ_ARRAY) begin
      seq_r <= SEQ_CMD;
    end
  end

  // ----------------------------------------------------------------
  // buffer-empty and all-done flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_empty_r <= 1'b1;
    end else if (launch_ok) begin
      buf_empty_r <= 1'b0;
    end else if (cmd_active_i & ~cmd_pending_i) begin
      buf_empty_r <= 1'b1;
    end else if (~cmd_active_i & ~cmd_pending_i) begin
      buf_empty_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      all_done_r <= 1'b1;
    end else if (launch_ok | ~buf_empty_r) begin
      all_done_r <= 1'b0;
    end else if (cmd_finish_i & ~cmd_pending_i) begin
      all_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // error flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      protect_violation_flag_r <= 1'b0;
    end else if (irq_evt[IRQ_PROTECT_VIOLATION_FLAG]) begin
      protect_violation_flag_r <= 1'b1;
    end else if (wr_status & pwdata_i[BIT_PROTECT_VIOLATION_FLAG]) begin
      protect_violation_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_error_flag_r <= 1'b0;
    end else if (irq_evt[IRQ_ACCESS_ERROR_FLAG] | (launch_req & ~div_written_r)) begin
      access_error_flag_r <= 1'b1;
    end else if (wr_status & pwdata_i[BIT_ACCESS_ERROR_FLAG]) begin
      access_error_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // verify result flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_r <= 1'b0;
    end else if (launch_ok) begin
      blank_r <= 1'b0;
    end else if (cmd_finish_i & is_verify_i & verify_erased_i) begin
      blank_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_r <= 1'b0;
    end else if (special_mode_i & cmd_finish_i & is_verify_i & ~verify_erased_i) begin
      fail_r <= 1'b1;
    end else if (special_mode_i & wr_status & pwdata_i[BIT_FAIL]) begin
      fail_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // protection guard and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scenario_r <= RST_SCENARIO;
    end else if (wr_acc && paddr_i == ADDR_PROTECTION_CONFIG
                 && scenario_ok(scenario_r, pwdata_i[2:0])) begin
      scenario_r <= pwdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_r <= RST_CONFIG;
      div_written_r <= 1'b0;
    end else begin
      if (wr_acc && paddr_i == ADDR_FLASH_CONFIGURATION) begin
        config_r <= pwdata_i[7:0];
      end
      if (wr_acc && paddr_i == ADDR_TIMEBASE_DIVIDER) begin
        div_written_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status (w1c, set wins) and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_r <= RST_IRQ;
      irq_mask_r <= RST_IRQ;
    end else begin
      irq_sts_r <= (irq_sts_r & ~((wr_acc && paddr_i == ADDR_IRQ_STATUS)
                    ? pwdata_i[IRQ_BITS-1:0] : RST_IRQ)) | irq_evt
                    | {{(IRQ_BITS-1){1'b0}}, launch_ok};
      if (wr_acc && paddr_i == ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata_i[IRQ_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status read image
  // ----------------------------------------------------------------
  always_comb begin
    status_rd = 8'h00;
    status_rd[BIT_BUF_EMPTY] = buf_empty_r;
    status_rd[BIT_ALL_DONE] = all_done_r;
    status_rd[BIT_PROTECT_VIOLATION_FLAG] = protect_violation_flag_r;
    status_rd[BIT_ACCESS_ERROR_FLAG] = access_error_flag_r;
    status_rd[BIT_BLANK] = blank_r;
    status_rd[BIT_FAIL] = special_mode_i & fail_r;
    status_rd[BIT_DONE] = special_mode_i & ~cmd_active_i;
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        unique case (paddr_i)
          ADDR_FLASH_STATUS: prdata_o <= {24'h00_0000, status_rd};
          ADDR_PROTECTION_CONFIG: prdata_o <= {29'h0000_0000, scenario_r};
          ADDR_FLASH_CONFIGURATION: prdata_o <= {24'h00_0000, config_r};
          ADDR_TIMEBASE_DIVIDER: prdata_o <= {31'h0000_0000, div_written_r};
          ADDR_IRQ_STATUS: prdata_o <= {28'h000_0000, irq_sts_r};
          ADDR_IRQ_MASK: prdata_o <= {28'h000_0000, irq_mask_r};
          default: pslverr_o <= 1'b1; // unmapped
        endcase
      end else if (psel_i & ~penable_i) begin
        unique case (paddr_i)
          ADDR_FLASH_STATUS, ADDR_PROTECTION_CONFIG, ADDR_FLASH_CONFIGURATION,
          ADDR_TIMEBASE_DIVIDER, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: pslverr_o <= 1'b0;
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch_o <= 1'b0;
      abort_o <= 1'b0;
      buf_empty_irq_o <= 1'b0;
      all_done_irq_o <= 1'b0;
      irq_o <= 1'b0;
      scenario_o <= RST_SCENARIO;
    end else begin
      launch_o <= launch_ok;
      abort_o <= zero_abort;
      buf_empty_irq_o <= buf_empty_r & config_r[BIT_BE_IE];
      all_done_irq_o <= all_done_r & config_r[BIT_AD_IE];
      irq_o <= |(irq_sts_r & irq_mask_r);
      scenario_o <= scenario_r;
    end
  end

  // rd_acc kept for symmetry of decode; reads are served from the setup phase
  logic unused_rd;
  assign unused_rd = rd_acc;

endmodule : flash_protect_status_flags

//--- flash_protect_status_flags_bench.sv
// bench: register-level tests of the flash status and guard block
`timescale 1ns/1ps
module flash_protect_status_flags_bench;
  import flash_guard_pkg::*;
  localparam logic [63:0] ALLOWED = 64'hFF5A_3C18_080C_0A0F;
  localparam logic [9:0] ST = ADDR_FLASH_STATUS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [9:0] paddr_i = 10'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic array_write_i = 1'b0, cmd_write_i = 1'b0, cmd_illegal_i = 1'b0, target_protected_i = 1'b0;
  logic is_verify_i = 1'b0, cmd_active_i = 1'b0, cmd_pending_i = 1'b0, cmd_finish_i = 1'b0;
  logic verify_erased_i = 1'b0, stop_req_i = 1'b0, special_mode_i = 1'b0;
  logic [31:0] prdata_o, q;
  logic pready_o, pslverr_o, launch_o, abort_o, buf_empty_irq_o, all_done_irq_o, irq_o, serr;
  logic [2:0] scenario_o;
  int err_total = 0, n_compared = 0, n_launch = 0, n_abort = 0;
  flash_protect_status_flags dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .array_write_i(array_write_i), .cmd_write_i(cmd_write_i), .cmd_illegal_i(cmd_illegal_i),
    .target_protected_i(target_protected_i), .is_verify_i(is_verify_i),
    .cmd_active_i(cmd_active_i), .cmd_pending_i(cmd_pending_i), .cmd_finish_i(cmd_finish_i),
    .verify_erased_i(verify_erased_i), .stop_req_i(stop_req_i),
    .special_mode_i(special_mode_i), .launch_o(launch_o), .abort_o(abort_o),
    .buf_empty_irq_o(buf_empty_irq_o), .all_done_irq_o(all_done_irq_o), .irq_o(irq_o),
    .scenario_o(scenario_o));
  // --------------------------------------------------------------
  // clock, event counters, helpers
  // --------------------------------------------------------------
  initial forever #2 clk_i = ~clk_i;
  // one-cycle pulses counted at the edge that samples them
  always @(posedge clk_i) begin
    if (launch_o === 1'b1) n_launch++;
    if (abort_o === 1'b1) n_abort++;
  end
  task automatic conclude;
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // apb transfer, holds the request until ready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      conclude();
    end
    q = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, q & m, e);
  endtask : rd
  // array write, code write, then launch by writing one to buffer empty
  task automatic go;
    array_write_i <= 1'b1;
    @(posedge clk_i);
    array_write_i <= 1'b0;
    cmd_write_i <= 1'b1;
    @(posedge clk_i);
    cmd_write_i <= 1'b0;
    wr(ST, 32'h0000_0080);
    repeat (4) @(posedge clk_i);
  endtask : go
  task automatic fin(input logic v);
    cmd_finish_i <= 1'b1;
    verify_erased_i <= v;
    @(posedge clk_i);
    cmd_finish_i <= 1'b0;
    @(posedge clk_i);
  endtask : fin
  task automatic rst(input int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : rst
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    rst(12);
    rd(ST, 32'h0000_00FF, 32'h0000_00C0, "status reset");
    rd(ADDR_PROTECTION_CONFIG, 32'hFFFF_FFFF, 32'h0000_0007, "prot reset");
    wr(ST, 32'h0000_0047);
    rd(ST, 32'h0000_00FF, 32'h0000_00C0, "status ro bits");
    chk("idle zero write", n_abort, 32'h0000_0000);
    apb(1'b0, 10'h3FC, 32'h0000_0000);
    chk("unmapped", {31'h0, serr}, 32'h0000_0001);
    wr(ADDR_FLASH_CONFIGURATION, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    chk("be irq", {30'h0, buf_empty_irq_o, all_done_irq_o}, 32'h0000_0002);
    wr(ADDR_FLASH_CONFIGURATION, 32'h0000_0040);
    repeat (2) @(posedge clk_i);
    chk("ad irq", {30'h0, buf_empty_irq_o, all_done_irq_o}, 32'h0000_0001);
    go();
    rd(ST, 32'h0000_0010, 32'h0000_0010, "no divider");
    wr(ADDR_TIMEBASE_DIVIDER, 32'h0000_0004);
    go();
    chk("error blocks", n_launch, 32'h0000_0000);
    wr(ST, 32'h0000_0010);
    rd(ST, 32'h0000_0010, 32'h0000_0000, "access_error_flag clear");
    array_write_i <= 1'b1;
    @(posedge clk_i);
    array_write_i <= 1'b0;
    wr(ST, 32'h0000_0000);
    rd(ST, 32'h0000_0010, 32'h0000_0010, "abort err");
    chk("abort pulse", n_abort, 32'h0000_0001);
    wr(ST, 32'h0000_0010);
    for (int i = 0; i < 2; i++) begin
      target_protected_i <= (i == 0);
      cmd_illegal_i <= (i == 1);
      go();
      rd(ST, 32'h0000_0030, i == 0 ? 32'h0000_0020 : 32'h0000_0010, "fault");
      wr(ST, 32'h0000_0030);
      rd(ST, 32'h0000_0030, 32'h0000_0000, "fault clear");
    end
    target_protected_i <= 1'b0;
    cmd_illegal_i <= 1'b0;
    chk("faults block", n_launch, 32'h0000_0000);
    cmd_active_i <= 1'b1;
    cmd_pending_i <= 1'b1;
    go();
    chk("launch", n_launch, 32'h0000_0001);
    rd(ST, 32'h0000_00C0, 32'h0000_0000, "busy flags");
    rd(ADDR_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001, "launch event");
    chk("masked irq", {31'h0, irq_o}, 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq on", {31'h0, irq_o}, 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq off", {31'h0, irq_o}, 32'h0000_0000);
    cmd_pending_i <= 1'b0;
    @(posedge clk_i);
    cmd_active_i <= 1'b0;
    fin(1'b0);
    rd(ST, 32'h0000_0040, 32'h0000_0040, "all done");
    chk("ad irq set", {31'h0, all_done_irq_o}, 32'h0000_0001);
    cmd_active_i <= 1'b1;
    stop_req_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    stop_req_i <= 1'b0;
    cmd_active_i <= 1'b0;
    rd(ST, 32'h0000_0010, 32'h0000_0010, "stop err");
    wr(ST, 32'h0000_0010);
    special_mode_i <= 1'b1;
    cmd_active_i <= 1'b1;
    rd(ST, 32'h0000_0001, 32'h0000_0000, "done busy");
    cmd_active_i <= 1'b0;
    rd(ST, 32'h0000_0001, 32'h0000_0001, "done idle");
    is_verify_i <= 1'b1;
    fin(1'b0);
    rd(ST, 32'h0000_0007, 32'h0000_0003, "verify fail");
    go();
    chk("fail blocks", n_launch, 32'h0000_0001);
    wr(ST, 32'h0000_0002);
    rd(ST, 32'h0000_0002, 32'h0000_0000, "fail clear");
    fin(1'b1);
    wr(ST, 32'h0000_0004);
    rd(ST, 32'h0000_0006, 32'h0000_0004, "blank set");
    special_mode_i <= 1'b0;
    is_verify_i <= 1'b0;
    wr(ST, 32'h0000_0002);
    rd(ST, 32'h0000_0003, 32'h0000_0000, "normal low bits");
    go();
    rd(ST, 32'h0000_0004, 32'h0000_0000, "blank cleared");
    chk("relaunch", n_launch, 32'h0000_0002);
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        rst(2);
        wr(ADDR_PROTECTION_CONFIG, f);
        wr(ADDR_PROTECTION_CONFIG, t);
        rd(ADDR_PROTECTION_CONFIG, 32'h0000_0007, ALLOWED[f * 8 + t] ? t : f, "scen");
      end
    end
    conclude();
  end
endmodule : flash_protect_status_flags_bench
bind flash_protect_status_flags flash_protect_status_flags_checker chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .launch_o(launch_o), .abort_o(abort_o), .scenario_o(scenario_o));

//--- flash_protect_status_flags_checker.sv
// checker: port-level assertions of the flash status and guard block
`timescale 1ns/1ps
module flash_protect_status_flags_checker
  import flash_guard_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic launch_o,
  input wire logic abort_o,
  input wire logic [2:0] scenario_o
);
  // allowed targets, one byte a source scenario
  localparam logic [63:0] ALLOWED = 64'hFF5A_3C18_080C_0A0F;
  logic pr_wr;
  logic st1;
  logic st0;
  // --------------------------------------------------------------
  // access decode
  // --------------------------------------------------------------
  assign pr_wr = psel_i && penable_i && pwrite_i && paddr_i == ADDR_PROTECTION_CONFIG;
  assign st1 = psel_i && penable_i && pwrite_i && paddr_i == ADDR_FLASH_STATUS
    && pwdata_i[BIT_BUF_EMPTY];
  assign st0 = psel_i && penable_i && pwrite_i && paddr_i == ADDR_FLASH_STATUS
    && !pwdata_i[BIT_BUF_EMPTY];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  chk_scen_legal: assert property ($changed(scenario_o) |-> ALLOWED[{$past(scenario_o), scenario_o}])
    else $error("scenario moved along a forbidden transition");
  chk_scen_write: assert property ($changed(scenario_o) |-> $past(pr_wr, 2))
    else $error("scenario changed without a protection write");
  chk_ready_resp: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready in the access phase");
  chk_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");
  chk_slverr_pair: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  chk_one_event: assert property (!(launch_o && abort_o))
    else $error("launch and abort together");
  chk_launch_cause: assert property (launch_o |-> $past(st1) || $past(st1, 2))
    else $error("launch without a one written to buffer empty");
  chk_abort_cause: assert property (abort_o |-> $past(st0) || $past(st0, 2))
    else $error("abort without a zero written to buffer empty");
endmodule : flash_protect_status_flags_checker
